// *** rtl/rms_pkg.sv ***
package rms_pkg;

  // Clock rate
  localparam int unsigned CLK_FREQ_HZ = 25000000;

  // Power-on reset window, figures in microseconds
  localparam int unsigned POR_MIN_US = 1000;
  localparam int unsigned POR_MAX_US = 100000;
  // Least time rounds down, but never below one cycle
  localparam int unsigned POR_CYCLES =
    (POR_MIN_US * (CLK_FREQ_HZ / 1000000) + 0) < 1 ? 1 : POR_MIN_US * (CLK_FREQ_HZ / 1000000);

  // Oscillator start-up, figure in nanoseconds at the nominal series inductance
  localparam int unsigned OSC_STARTUP_NS = 1500000;
  localparam int unsigned OSC_LS_NOM_UH = 30000;
  // Longest time rounds down
  localparam int unsigned OSC_STARTUP_CYCLES = OSC_STARTUP_NS / (1000000000 / CLK_FREQ_HZ);

  // Standby to active settling, nanoseconds
  localparam int unsigned SETTLE_NS = 130000;
  localparam int unsigned SETTLE_CYCLES = SETTLE_NS / (1000000000 / CLK_FREQ_HZ);

  // Least radio-enable high pulse before transmit, nanoseconds
  localparam int unsigned CE_MIN_NS = 10000;
  localparam int unsigned CE_MIN_CYCLES =
    (CE_MIN_NS + (1000000000 / CLK_FREQ_HZ) - 1) / (1000000000 / CLK_FREQ_HZ);

  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;

  typedef enum logic [3:0]
  {
    RMS_ST_POR = 4'b0000,
    RMS_ST_PDOWN = 4'b0001,
    RMS_ST_OSC_START = 4'b0010,
    RMS_ST_STBY1 = 4'b0011,
    RMS_ST_STBY2 = 4'b0100,
    RMS_ST_RX_SETTLE = 4'b0101,
    RMS_ST_RX = 4'b0110,
    RMS_ST_TX_SETTLE = 4'b0111,
    RMS_ST_TX = 4'b1000
  } rms_state_t;

endpackage

// *** rtl/rms_timer.sv ***
`timescale 1ns/100ps
module rms_timer
  import rms_pkg::*;
#(
  parameter int unsigned W = CNT_W
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);

  logic [W-1:0] cnt_r;
  logic busy_r;

  // Done pulses for one cycle when a loaded count has run out
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      o_done <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      if (i_load)
      begin
        cnt_r <= i_count;
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        if (cnt_r <= W'(1))
        begin
          busy_r <= 1'b0;
          o_done <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r - W'(1);
        end
      end
    end
  end

endmodule

// *** rtl/rms_mode_fsm.sv ***
`timescale 1ns/100ps
// Contract
// - After supply threshold, sit in power-on reset until entering power down.
// - Power-on reset lasts between 1 ms and 100 ms.
// - One state machine governs all mode transitions from register bits and inputs.
// - Transition states are time-bounded and pass on to the next mode.
// - Oscillator start-up from power down to standby within 1.5 ms.
// - Power down keeps register contents and serial interface alive.
// - Clearing the power-up bit moves the device to power down.
// - Setting the power-up bit moves the device to standby-I.
// - Active modes only with radio-enable high; low returns to standby-I. TX settling and transmit run on with enable low until the packet is out.
// - Transmitter with enable high and empty TX FIFO sits in standby-II.
// - Packet upload in standby-II starts settling at once, sends after 130 us.
// - Both standby modes keep registers and accept serial access.
// - Receive entered with power-up, receiver select and enable all high.
// - Transmit needs power-up, transmitter role, payload and enable over 10 us.
// - After a packet, empty FIFO gives standby-II, else keep transmitting.
// - Standby to active, or between transmit and receive, within 130 us.
module rms_mode_fsm
  import rms_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES,
  parameter int unsigned OSC_CNT = OSC_STARTUP_CYCLES,
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES,
  parameter int unsigned CE_MIN_CNT = CE_MIN_CYCLES
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_power_up_bit,
  input wire logic i_primary_receiver_select,
  input wire logic i_radio_enable,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tx_packet_done,
  output logic o_por_active,
  output logic o_power_down,
  output logic o_osc_starting,
  output logic o_standby1,
  output logic o_standby2,
  output logic o_settling,
  output logic o_rx_active,
  output logic o_tx_active,
  output logic o_spi_enable,
  output logic [3:0] o_state
);

  rms_state_t state_r;
  rms_state_t state_nxt;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic [CNT_W-1:0] ce_cnt_r;
  logic ce_long;
  logic tx_single_r;
  logic por_armed_r;
  logic tmr_load_all;
  logic [CNT_W-1:0] tmr_count_all;

  // Shared timer: one transition state runs at a time
  rms_timer #(.W(CNT_W)) u_timer
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_clk_en),
    .i_load(tmr_load_all),
    .i_count(tmr_count_all),
    .o_done(tmr_done)
  );

  // Radio-enable high time, saturating
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ce_cnt_r <= CNT_ZERO;
    end
    else if (i_clk_en)
    begin
      if (!i_radio_enable)
      begin
        ce_cnt_r <= CNT_ZERO;
      end
      else if (!ce_long)
      begin
        ce_cnt_r <= ce_cnt_r + CNT_W'(1);
      end
    end
  end

  assign ce_long = (ce_cnt_r >= CNT_W'(CE_MIN_CNT));

  // Enable falling after the minimum high time sends one packet then drops to standby-I
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_single_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (state_r == RMS_ST_STBY1)
      begin
        tx_single_r <= 1'b0;
      end
      else if (ce_long && !i_radio_enable)
      begin
        tx_single_r <= 1'b1;
      end
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_count = CNT_ZERO;
    case (state_r)
      RMS_ST_POR:
      begin
        if (tmr_done)
        begin
          state_nxt = RMS_ST_PDOWN;
        end
      end
      RMS_ST_PDOWN:
      begin
        if (i_power_up_bit)
        begin
          state_nxt = RMS_ST_OSC_START;
          tmr_load = 1'b1;
          tmr_count = CNT_W'(OSC_CNT);
        end
      end
      RMS_ST_OSC_START:
      begin
        if (tmr_done)
        begin
          state_nxt = RMS_ST_STBY1;
        end
      end
      RMS_ST_STBY1:
      begin
        if (i_radio_enable && i_primary_receiver_select)
        begin
          state_nxt = RMS_ST_RX_SETTLE;
          tmr_load = 1'b1;
          tmr_count = CNT_W'(SETTLE_CNT);
        end
        else if (i_radio_enable && !i_tx_fifo_empty && (ce_long || tx_single_r))
        begin
          state_nxt = RMS_ST_TX_SETTLE;
          tmr_load = 1'b1;
          tmr_count = CNT_W'(SETTLE_CNT);
        end
        else if (i_radio_enable && i_tx_fifo_empty && ce_long)
        begin
          state_nxt = RMS_ST_STBY2;
        end
      end
      RMS_ST_STBY2:
      begin
        if (!i_radio_enable || i_primary_receiver_select)
        begin
          state_nxt = RMS_ST_STBY1;
        end
        else if (!i_tx_fifo_empty)
        begin
          state_nxt = RMS_ST_TX_SETTLE;
          tmr_load = 1'b1;
          tmr_count = CNT_W'(SETTLE_CNT);
        end
      end
      RMS_ST_RX_SETTLE:
      begin
        if (!i_radio_enable)
        begin
          state_nxt = RMS_ST_STBY1;
        end
        else if (tmr_done)
        begin
          state_nxt = RMS_ST_RX;
        end
      end
      RMS_ST_RX:
      begin
        if (!i_radio_enable)
        begin
          state_nxt = RMS_ST_STBY1;
        end
        else if (!i_primary_receiver_select)
        begin
          state_nxt = i_tx_fifo_empty ? RMS_ST_STBY2 : RMS_ST_TX_SETTLE;
          tmr_load = !i_tx_fifo_empty;
          tmr_count = CNT_W'(SETTLE_CNT);
        end
      end
      RMS_ST_TX_SETTLE:
      begin
        // Pulse mode: settling continues after enable falls
        if (tmr_done)
        begin
          state_nxt = RMS_ST_TX;
        end
      end
      RMS_ST_TX:
      begin
        // Transmit holds until the packet is out, whatever the enable does
        if (i_tx_packet_done)
        begin
          if (!i_radio_enable || tx_single_r)
          begin
            state_nxt = RMS_ST_STBY1;
          end
          else if (i_primary_receiver_select)
          begin
            state_nxt = RMS_ST_RX_SETTLE;
            tmr_load = 1'b1;
            tmr_count = CNT_W'(SETTLE_CNT);
          end
          else if (i_tx_fifo_empty)
          begin
            state_nxt = RMS_ST_STBY2;
          end
          else
          begin
            state_nxt = RMS_ST_TX;
          end
        end
      end
      default:
      begin
        state_nxt = RMS_ST_PDOWN;
      end
    endcase
    // Power-up bit low beats every other cause, except reset itself
    if (state_r != RMS_ST_POR && !i_power_up_bit)
    begin
      state_nxt = RMS_ST_PDOWN;
      tmr_load = 1'b0;
    end
  end

  // Reset timer is armed one cycle after release; reset value stays constant
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      por_armed_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      por_armed_r <= 1'b1;
    end
  end

  always_comb
  begin
    tmr_load_all = tmr_load;
    tmr_count_all = tmr_count;
    if (!por_armed_r)
    begin
      tmr_load_all = 1'b1;
      tmr_count_all = CNT_W'(POR_CNT);
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_r <= RMS_ST_POR;
    end
    else if (i_clk_en)
    begin
      state_r <= state_nxt;
    end
  end

  // Registered mode outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_por_active <= 1'b1;
      o_power_down <= 1'b0;
      o_osc_starting <= 1'b0;
      o_standby1 <= 1'b0;
      o_standby2 <= 1'b0;
      o_settling <= 1'b0;
      o_rx_active <= 1'b0;
      o_tx_active <= 1'b0;
      o_spi_enable <= 1'b0;
      o_state <= 4'h0;
    end
    else if (i_clk_en)
    begin
      o_por_active <= (state_nxt == RMS_ST_POR);
      o_power_down <= (state_nxt == RMS_ST_PDOWN);
      o_osc_starting <= (state_nxt == RMS_ST_OSC_START);
      o_standby1 <= (state_nxt == RMS_ST_STBY1);
      o_standby2 <= (state_nxt == RMS_ST_STBY2);
      o_settling <= (state_nxt == RMS_ST_RX_SETTLE) || (state_nxt == RMS_ST_TX_SETTLE);
      o_rx_active <= (state_nxt == RMS_ST_RX);
      o_tx_active <= (state_nxt == RMS_ST_TX);
      o_spi_enable <= (state_nxt != RMS_ST_POR);
      o_state <= state_nxt;
    end
  end

endmodule

// *** testbench/rms_mode_fsm_monitor.sv ***
`timescale 1ns/100ps
module rms_mode_fsm_monitor
  import rms_pkg::*;
#(
  parameter int unsigned OSC_CNT = OSC_STARTUP_CYCLES,
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_power_up_bit,
  input wire logic i_primary_receiver_select,
  input wire logic i_radio_enable,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tx_packet_done,
  input wire logic o_por_active,
  input wire logic o_power_down,
  input wire logic o_osc_starting,
  input wire logic o_standby1,
  input wire logic o_standby2,
  input wire logic o_settling,
  input wire logic o_rx_active,
  input wire logic o_tx_active,
  input wire logic o_spi_enable
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  logic [15:0] dwell_r;
  // Frozen with the clock enable, so the bound holds in enabled cycles only
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      dwell_r <= 16'h0000;
    else if (!(o_osc_starting || o_settling))
      dwell_r <= 16'h0000;
    else if (i_clk_en)
      dwell_r <= dwell_r + 16'h0001;
  end
  a_clear_pdown: assert property (
    i_clk_en && !i_power_up_bit && !o_por_active |=> o_power_down) else $error("no pd");
  a_spi_alive: assert property (
    o_spi_enable == !o_por_active) else $error("spi");
  a_pup_osc: assert property (
    o_power_down && i_clk_en && i_power_up_bit |=> o_osc_starting) else $error("no osc");
  a_rx_via_settle: assert property (
    $rose(o_rx_active) |-> $past(o_settling) && $past(i_radio_enable)) else $error("rx");
  a_en_low_exit: assert property (
    i_clk_en && i_power_up_bit && !i_radio_enable && (o_rx_active || o_standby2)
    |=> o_standby1) else $error("en low");
  a_tx_exit_done: assert property (
    $fell(o_tx_active) |-> $past(i_tx_packet_done) || o_power_down) else $error("tx exit");
  a_stby2_empty: assert property (
    $rose(o_standby2) |-> $past(i_tx_fifo_empty) && $past(i_radio_enable)) else $error("sb2");
  a_stby2_upload: assert property (
    o_standby2 && i_clk_en && i_power_up_bit && i_radio_enable && !i_tx_fifo_empty
    && !i_primary_receiver_select |=> o_settling) else $error("upload");
  a_osc_no_active: assert property (
    o_osc_starting |=> !(o_settling || o_rx_active || o_tx_active || o_standby2))
    else $error("early active");
  a_transit_bounded: assert property (
    dwell_r <= OSC_CNT + SETTLE_CNT + 2) else $error("transit");
  c_rx: cover property (o_rx_active);
  c_tx: cover property ($rose(o_tx_active));
  c_sb2: cover property (o_standby2);
endmodule

// *** testbench/rms_txdp_model.sv ***
`timescale 1ns/100ps
module rms_txdp_model
#(
  parameter int PKT = 5
)
(
  input wire logic i_clk_sys,
  input wire logic i_push,
  input wire logic i_tx_active,
  output logic o_tx_fifo_empty,
  output logic o_tx_packet_done
);
  int cnt = 0;
  int age = 0;
  initial o_tx_packet_done = 1'b0;
  assign o_tx_fifo_empty = (cnt == 0);
  // Pops at the done pulse so empty is valid when the pulse is sampled
  always @(posedge i_clk_sys)
  begin
    o_tx_packet_done <= 1'b0;
    if (i_push)
      cnt <= cnt + 1;
    if (i_tx_active)
      age <= age + 1;
    if (i_tx_active && age == PKT - 1)
    begin
      o_tx_packet_done <= 1'b1;
      cnt <= cnt - 1;
      age <= 0;
    end
  end
endmodule

// *** testbench/rms_mode_fsm_test.sv ***
`timescale 1ns/100ps
module rms_mode_fsm_test;
  import rms_pkg::*;
  localparam int POR_N = 8;
  localparam int OSC_N = 12;
  localparam int SET_N = 6;
  localparam int CE_N = 3;
  logic clk, rst_b, cke, pup, rxs, en, push, emp, done, spi, txa;
  logic [3:0] st;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  rms_mode_fsm #(.POR_CNT(POR_N), .OSC_CNT(OSC_N), .SETTLE_CNT(SET_N), .CE_MIN_CNT(CE_N))
  i_rms_mode_fsm (.i_clk_sys(clk), .i_rst_b(rst_b), .i_clk_en(cke), .i_power_up_bit(pup),
    .i_primary_receiver_select(rxs), .i_radio_enable(en), .i_tx_fifo_empty(emp),
    .i_tx_packet_done(done), .o_por_active(), .o_power_down(), .o_osc_starting(),
    .o_standby1(), .o_standby2(), .o_settling(), .o_rx_active(), .o_tx_active(txa),
    .o_spi_enable(spi), .o_state(st));
  rms_txdp_model i_rms_txdp_model (.i_clk_sys(clk), .i_push(push), .i_tx_active(txa),
    .o_tx_fifo_empty(emp), .o_tx_packet_done(done));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s: %h not %h", $time, m, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi, input string m);
    checks_done++;
    if (v < lo || v > hi)
    begin
      err_count++;
      $display("[ERR] %0t %s: %0d", $time, m, v);
    end
  endtask

  task automatic wait_st(input logic [3:0] s, input int lim);
    n = 0;
    while (st !== s && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic t_por;
    chk(st, RMS_ST_POR, "por");
    chk({3'b000, spi}, 4'h0, "spi por");
    rst_b = 1'b1;
    wait_st(RMS_ST_PDOWN, 50);
    rng(n, POR_N, POR_N + 4, "por len");
    chk({3'b000, spi}, 4'h1, "spi");
    $display("t_por done");
  endtask

  task automatic t_wake;
    pup = 1'b1;
    @(negedge clk);
    chk(st, RMS_ST_OSC_START, "osc");
    cke = 1'b0;
    repeat (2 * OSC_N) @(negedge clk);
    chk(st, RMS_ST_OSC_START, "frozen");
    cke = 1'b1;
    wait_st(RMS_ST_STBY1, 60);
    rng(n, OSC_N - 1, OSC_N + 2, "osc len");
    $display("t_wake done");
  endtask

  task automatic t_rx;
    rxs = 1'b1;
    en = 1'b1;
    @(negedge clk);
    chk(st, RMS_ST_RX_SETTLE, "rx set");
    wait_st(RMS_ST_RX, 40);
    rng(n, SET_N, SET_N + 2, "settle");
    en = 1'b0;
    @(negedge clk);
    chk(st, RMS_ST_STBY1, "rx off");
    $display("t_rx done");
  endtask

  task automatic t_tx;
    rxs = 1'b0;
    push = 1'b1;
    repeat (2) @(negedge clk);
    push = 1'b0;
    en = 1'b1;
    wait_st(RMS_ST_TX, 60);
    rng(n, CE_N + SET_N, CE_N + SET_N + 4, "tx in");
    repeat (7) @(negedge clk);
    chk(st, RMS_ST_TX, "tx more");
    wait_st(RMS_ST_STBY2, 20);
    chk(st, RMS_ST_STBY2, "sb2");
    push = 1'b1;
    @(negedge clk);
    push = 1'b0;
    wait_st(RMS_ST_TX_SETTLE, 3);
    chk(st, RMS_ST_TX_SETTLE, "upload");
    en = 1'b0;
    wait_st(RMS_ST_STBY1, 30);
    chk(st, RMS_ST_STBY1, "one pkt");
    $display("t_tx done");
  endtask

  task automatic t_drop;
    rxs = 1'b1;
    en = 1'b1;
    wait_st(RMS_ST_RX, 40);
    chk(st, RMS_ST_RX, "rx again");
    pup = 1'b0;
    @(negedge clk);
    chk(st, RMS_ST_PDOWN, "pd");
    en = 1'b0;
    rst_b = 1'b0;
    @(negedge clk);
    chk(st, RMS_ST_POR, "rst");
    rst_b = 1'b1;
    wait_st(RMS_ST_PDOWN, 50);
    rng(n, POR_N, POR_N + 4, "por again");
    $display("t_drop done");
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      end_sim;
    end
  end

  initial
  begin
    {rst_b, cke, pup, rxs, en, push} = 6'h10;
    repeat (8) @(negedge clk);
    t_por;
    t_wake;
    t_rx;
    t_tx;
    t_drop;
    end_sim;
  end
endmodule

bind rms_mode_fsm rms_mode_fsm_monitor #(.OSC_CNT(OSC_CNT), .SETTLE_CNT(SETTLE_CNT))
  i_rms_mode_fsm_monitor (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
    .i_power_up_bit(i_power_up_bit), .i_primary_receiver_select(i_primary_receiver_select),
    .i_radio_enable(i_radio_enable), .i_tx_fifo_empty(i_tx_fifo_empty),
    .i_tx_packet_done(i_tx_packet_done), .o_por_active(o_por_active),
    .o_power_down(o_power_down), .o_osc_starting(o_osc_starting), .o_standby1(o_standby1),
    .o_standby2(o_standby2), .o_settling(o_settling), .o_rx_active(o_rx_active),
    .o_tx_active(o_tx_active), .o_spi_enable(o_spi_enable));
